// >>> test/host_reader.sv
// Host-side reader model that takes reply words and may stall or accept slowly.
`timescale 1ns/100ps
module host_reader (
	input wire logic clock,
	input wire logic replyValid,
	input wire logic [31:0] replyData,
	input wire logic hold,
	input wire logic slow,
	output logic replyReady
);
	logic [31:0] got[$];
	logic phase = 1'b0;
	logic ready_q = 1'b0;
	assign replyReady = ready_q;
	// ==========================================================
	// Acceptance
	// host drains words
	always @(posedge clock) begin
		if (replyValid && replyReady) begin
			got.push_back(replyData);
		end
		phase <= ~phase;
		ready_q <= !hold && (!slow || phase);
	end
endmodule

// >>> test/list_mode_event_streamer_bench.sv
// Self-checking bench for the list-mode event streamer.
`timescale 1ns/100ps
module list_mode_event_streamer_bench;
	import list_mode_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic startCmd = 1'b0;
	logic stopCmd = 1'b0;
	logic pulseValid = 1'b0;
	logic readRequest = 1'b0;
	logic hold = 1'b0;
	logic slow = 1'b0;
	logic [AMP_W-1:0] pulseAmplitude = '0;
	logic replyValid, replyReady, replyBusy, acquiring, wordsDropped;
	logic [WORD_W-1:0] replyData;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	// Short queue and time-word period keep the run brief.
	list_mode_event_streamer #(.FIFO_DEPTH(16), .TIME_WORD_US(8)) list_mode_event_streamer_inst (
		.clock(clock), .reset_n(reset_n), .startCmd(startCmd), .stopCmd(stopCmd),
		.pulseValid(pulseValid), .pulseAmplitude(pulseAmplitude), .readRequest(readRequest),
		.replyValid(replyValid), .replyReady(replyReady), .replyData(replyData),
		.replyBusy(replyBusy), .acquiring(acquiring), .wordsDropped(wordsDropped));
	host_reader host_reader_inst (.clock(clock), .replyValid(replyValid),
		.replyData(replyData), .hold(hold), .slow(slow), .replyReady(replyReady));
	always #12.5 clock = ~clock;
	// ==========================================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmd(input bit st);
		@(posedge clock);
		startCmd <= st;
		stopCmd <= !st;
		@(posedge clock);
		startCmd <= 1'b0;
		stopCmd <= 1'b0;
		@(negedge clock);
	endtask
	task automatic pulseIn(input logic [9:0] amp);
		@(posedge clock);
		pulseValid <= 1'b1;
		pulseAmplitude <= amp;
		@(posedge clock);
		pulseValid <= 1'b0;
	endtask
	// The awkward read stalls the host with the buffer full and asks again while busy.
	task automatic readAll(input int n, input bit awk);
		int k;
		host_reader_inst.got.delete();
		@(posedge clock);
		hold <= awk;
		slow <= awk;
		readRequest <= 1'b1;
		@(posedge clock);
		readRequest <= 1'b0;
		if (awk) begin
			repeat (3) @(posedge clock);
			readRequest <= 1'b1;
			@(posedge clock);
			readRequest <= 1'b0;
			repeat (16) @(posedge clock);
			chk("held header", n * 4, replyData);
			hold <= 1'b0;
		end
		k = 0;
		while ((replyBusy || replyValid || host_reader_inst.got.size() == 0) && k < 2000) begin
			@(posedge clock);
			k++;
		end
		repeat (10) @(posedge clock);
		slow <= 1'b0;
		chk("reply length", n + 1, host_reader_inst.got.size());
		if (host_reader_inst.got.size() > 0) begin
			chk("byte count", n * 4, host_reader_inst.got[0]);
		end
	endtask
	// ==========================================================
	// Scenarios
	task automatic testPulses();
		chk("idle acquiring", 0, acquiring);
		cmd(1);
		chk("acquiring", 1, acquiring);
		repeat (8) @(posedge clock);
		pulseIn(10'h080);
		repeat (48) @(posedge clock);
		pulseIn(10'h3ff);
		cmd(0);
		chk("stopped", 0, acquiring);
		pulseIn(10'h055);
		readAll(2, 0);
		chk("pulse word 0", {1'b0, 10'h080, 21'd0}, host_reader_inst.got[1]);
		chk("pulse word 1", {1'b0, 10'h3ff, 21'd1}, host_reader_inst.got[2]);
		$display("pulse words done");
	endtask
	task automatic testTime();
		cmd(1);
		repeat (318) @(posedge clock);
		// This pulse lands on the eighth tick, so the time word must queue right behind it.
		pulseIn(10'h1c3);
		repeat (20) @(posedge clock);
		cmd(0);
		readAll(2, 0);
		chk("boundary pulse", {1'b0, 10'h1c3, 21'd7}, host_reader_inst.got[1]);
		chk("time word", {1'b1, 10'h000, 21'd8}, host_reader_inst.got[2]);
		repeat (400) @(posedge clock);
		readAll(0, 0);
		$display("time words done");
	endtask
	task automatic testFull();
		cmd(1);
		@(posedge clock);
		pulseValid <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			pulseAmplitude <= 10'(i);
			@(posedge clock);
		end
		pulseValid <= 1'b0;
		@(negedge clock);
		chk("dropped flag", 1, wordsDropped);
		cmd(0);
		readAll(16, 1);
		for (int i = 0; i < 16; i++) begin
			chk("queued word", {1'b0, 10'(i), 21'd0}, host_reader_inst.got[i + 1]);
		end
		cmd(1);
		chk("dropped cleared", 0, wordsDropped);
		pulseIn(10'h02a);
		cmd(0);
		readAll(1, 0);
		chk("word after drain", {1'b0, 10'h02a, 21'd0}, host_reader_inst.got[1]);
		$display("full queue done");
	endtask
	// ==========================================================
	// Run control
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		testPulses();
		testTime();
		testFull();
		end_sim();
	end
endmodule

// >>> verilog/list_mode_event_streamer.sv
// List-mode framer: pulse and time-only words into a deep queue, read out in replies.
// Overview of operation
// - While acquiring, every detected pulse that finds the queue not full yields exactly one 32-bit queue word.
// - Pulse word: bit 31 clear, amplitude in 30-21, timestamp in 20-0.
// - A 21-bit microsecond timestamp counter advances each microsecond and wraps.
// - A time-only word is queued every 1.048576 seconds.
// - Time-only word: bit 31 set, bits 30-21 clear, bits 20-0 hold the microsecond time it was due at.
// - All pulse and time-only words wait in a 128K-entry first-in first-out queue; the byte count bypasses it.
// - With the queue full, every new word is discarded until space frees.
// - A read reply starts with the byte count, then that many bytes.
// - A start command makes the block begin producing words.
// - A stop command makes the block stop producing pulse and time words.
`timescale 1ns/100ps
module list_mode_event_streamer
	import list_mode_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEPTH_WORDS,
	parameter int TIME_WORD_US = TIME_WORD_PERIOD_US
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic startCmd,
	input wire logic stopCmd,
	input wire logic pulseValid,
	input wire logic [AMP_W-1:0] pulseAmplitude,
	input wire logic readRequest,
	output logic replyValid,
	input wire logic replyReady,
	output logic [WORD_W-1:0] replyData,
	output logic replyBusy,
	output logic acquiring,
	output logic wordsDropped
);
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int CW = PW + 1;
	localparam int DW = $clog2(CYCLES_PER_US);
	localparam int IW = $clog2(TIME_WORD_US + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
	localparam logic [DW-1:0] DIV_LAST = DW'(CYCLES_PER_US - 1);
	localparam logic [IW-1:0] INTERVAL_LAST = IW'(TIME_WORD_US - 1);

	// ==========================================================
	// Elaboration checks
	if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH || CW > WORD_W - 2) begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two that fits the byte count.");
	end
	if (TIME_WORD_US < 2 || CYCLES_PER_US < 2) begin : g_bad_timing
		$error("Tick and time-word periods must be at least two.");
	end

	typedef struct packed {
		logic acquire;
		logic [DW-1:0] div;
		logic [TS_W-1:0] ts;
		logic [IW-1:0] interval;
		logic timePending;
		logic [TS_W-1:0] timeValue;
		logic [PW-1:0] wrPtr;
		logic [PW-1:0] rdPtr;
		logic [CW-1:0] count;
		reply_state_t state;
		logic [CW-1:0] remain;
		logic stageValid;
		logic dropped;
	} streamer_state_t;

	localparam streamer_state_t RESET_STATE = '{
		acquire: 1'b0, div: '0, ts: '0, interval: '0, timePending: 1'b0,
		timeValue: '0, wrPtr: '0, rdPtr: '0, count: '0, state: REPLY_IDLE,
		remain: '0, stageValid: 1'b0, dropped: 1'b0};

	streamer_state_t s_q, s_d;
	logic [WORD_W-1:0] queueMem [FIFO_DEPTH];
	logic [WORD_W-1:0] rdWord_q;
	logic usTick, timeEvent, full;
	logic wrEn, wantWrite, rdIssue;
	logic [WORD_W-1:0] wrWord;
	logic bufInValid, bufInReady, stageTaken;
	logic [WORD_W-1:0] bufInData;

	function automatic logic [WORD_W-1:0] pulse_word(input logic [AMP_W-1:0] amp,
			input logic [TS_W-1:0] ts);
		pulse_word = {1'b0, amp, ts};
	endfunction

	function automatic logic [WORD_W-1:0] time_word(input logic [TS_W-1:0] ts);
		time_word = {1'b1, {(WORD_W - 1 - TS_W){1'b0}}, ts};
	endfunction

	// ==========================================================
	// Word production
	assign usTick = s_q.acquire && (s_q.div == DIV_LAST);
	assign timeEvent = usTick && (s_q.interval == INTERVAL_LAST);
	assign full = (s_q.count == DEPTH_C);
	assign stageTaken = (s_q.state == REPLY_DATA) && s_q.stageValid && bufInReady;
	assign rdIssue = (s_q.state == REPLY_DATA) && (s_q.remain != '0)
		&& (!s_q.stageValid || stageTaken);

	// A pulse and a time-only word may coincide; the pulse goes first and the
	// time word waits for a cycle with no pulse, keeping the time it was due at.
	// one word per pulse
	always_comb begin
		wantWrite = 1'b0;
		wrWord = '0;
		if (s_q.acquire && pulseValid) begin
			wantWrite = 1'b1;
			wrWord = pulse_word(pulseAmplitude, s_q.ts);
		end else if (s_q.acquire && s_q.timePending) begin
			wantWrite = 1'b1;
			wrWord = time_word(s_q.timeValue);
		end
	end
	assign wrEn = wantWrite && !full;

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;
		if (s_q.acquire) begin
			s_d.div = usTick ? '0 : s_q.div + DW'(1);
		end
		if (usTick) begin
			s_d.ts = s_q.ts + TS_W'(1);
			s_d.interval = timeEvent ? '0 : s_q.interval + IW'(1);
		end
		if (s_q.acquire && !pulseValid && s_q.timePending) begin
			s_d.timePending = 1'b0;
		end
		if (timeEvent) begin
			s_d.timePending = 1'b1;
			s_d.timeValue = s_q.ts + TS_W'(1);
		end
		if (wantWrite && full) begin
			s_d.dropped = 1'b1;
		end
		if (wrEn) begin
			s_d.wrPtr = s_q.wrPtr + PW'(1);
		end
		if (rdIssue) begin
			s_d.rdPtr = s_q.rdPtr + PW'(1);
		end
		s_d.count = s_q.count + CW'(wrEn) - CW'(rdIssue);
		if (stopCmd) begin
			s_d.acquire = 1'b0;
			s_d.timePending = 1'b0;
		end
		if (startCmd) begin
			s_d.acquire = 1'b1;
			s_d.ts = '0;
			s_d.div = '0;
			s_d.interval = '0;
			s_d.timePending = 1'b0;
			s_d.dropped = 1'b0;
		end
		case (s_q.state)
			REPLY_IDLE: begin
				if (readRequest) begin
					s_d.remain = s_q.count;
					s_d.state = REPLY_HEADER;
				end
			end
			REPLY_HEADER: begin
				if (bufInReady) begin
					s_d.state = (s_q.remain == '0) ? REPLY_IDLE : REPLY_DATA;
				end
			end
			REPLY_DATA: begin
				if (rdIssue) begin
					s_d.remain = s_q.remain - CW'(1);
					s_d.stageValid = 1'b1;
				end else if (stageTaken) begin
					s_d.stageValid = 1'b0;
				end
				if (s_q.remain == '0 && (!s_q.stageValid || stageTaken)) begin
					s_d.state = REPLY_IDLE;
				end
			end
			default: begin
				s_d.state = REPLY_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// The queue is far too deep for flops, so it gets a registered read port
	// that maps onto block memory.
	always_ff @(posedge clock) begin
		if (wrEn) begin
			queueMem[s_q.wrPtr] <= wrWord;
		end
		if (rdIssue) begin
			rdWord_q <= queueMem[s_q.rdPtr];
		end
	end

	// ==========================================================
	// Reply path
	assign bufInValid = (s_q.state == REPLY_HEADER)
		|| ((s_q.state == REPLY_DATA) && s_q.stageValid);
	assign bufInData = (s_q.state == REPLY_HEADER)
		? {{(WORD_W - CW - 2){1'b0}}, s_q.remain, 2'b00} : rdWord_q;

	stream_buffer2 #(
		.WIDTH(WORD_W)
	) u_reply_buffer (
		.clock(clock),
		.reset_n(reset_n),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.inData(bufInData),
		.outValid(replyValid),
		.outReady(replyReady),
		.outData(replyData)
	);

	assign replyBusy = (s_q.state != REPLY_IDLE);
	assign acquiring = s_q.acquire;
	assign wordsDropped = s_q.dropped;

	// ==========================================================
	// Checks
	a_pulse_word: assert property (@(posedge clock) disable iff (!reset_n)
		(s_q.acquire && pulseValid && !full) |=> ($past(wrEn)
		&& queueMem[$past(s_q.wrPtr)] == {1'b0, $past(pulseAmplitude), $past(s_q.ts)}))
		else $error("Pulse did not become one pulse word.");

	a_word_layout: assert property (@(posedge clock) disable iff (!reset_n)
		(wrEn && !wrWord[TYPE_BIT]) |-> wrWord[AMP_LSB-1:0] == s_q.ts)
		else $error("Pulse word carries a wrong timestamp.");

	a_stamp_advance: assert property (@(posedge clock) disable iff (!reset_n)
		(usTick && !startCmd) |=> (s_q.ts == $past(s_q.ts) + TS_W'(1)) ##1 !usTick[*8])
		else $error("Timestamp did not advance once per microsecond.");

	a_time_insert: assert property (@(posedge clock) disable iff (!reset_n)
		(timeEvent && !startCmd && !stopCmd) |=> s_q.timePending
		&& s_q.timeValue == $past(s_q.ts) + TS_W'(1))
		else $error("Time-only word was not scheduled.");

	a_time_layout: assert property (@(posedge clock) disable iff (!reset_n)
		(wrEn && wrWord[TYPE_BIT]) |-> wrWord[WORD_W-2:TS_W] == '0
		&& wrWord[TS_W-1:0] == s_q.timeValue && !pulseValid)
		else $error("Time-only word badly formed.");

	a_depth_bound: assert property (@(posedge clock) disable iff (!reset_n)
		s_q.count <= DEPTH_C && s_q.remain <= s_q.count)
		else $error("Queue fill exceeds its depth.");

	a_full_drop: assert property (@(posedge clock) disable iff (!reset_n)
		(full && wantWrite && !rdIssue && !startCmd) |=> s_q.count == DEPTH_C && s_q.dropped
		&& s_q.wrPtr == $past(s_q.wrPtr))
		else $error("Word written into a full queue.");

	a_header_first: assert property (@(posedge clock) disable iff (!reset_n)
		(s_q.state == REPLY_IDLE && readRequest) |=> bufInValid
		&& bufInData == {{(WORD_W - CW - 2){1'b0}}, $past(s_q.count), 2'b00})
		else $error("Reply did not open with the byte count.");

	a_start_clear: assert property (@(posedge clock) disable iff (!reset_n)
		startCmd |=> s_q.acquire && s_q.ts == '0 && !s_q.timePending)
		else $error("Start did not clear the timestamp.");

	a_stop_quiet: assert property (@(posedge clock) disable iff (!reset_n)
		(stopCmd && !startCmd) |=> !s_q.acquire && !wantWrite && !s_q.timePending)
		else $error("Words produced after stop.");
endmodule

// >>> verilog/list_mode_pkg.sv
// Shared constants for the list-mode event streamer.
package list_mode_pkg;
	// ==========================================================
	// Word layout
	localparam int WORD_W = 32;
	localparam int TYPE_BIT = 31;
	localparam int AMP_W = 10;
	localparam int AMP_LSB = 21;
	localparam int TS_W = 21;
	localparam int BYTES_PER_WORD = 4;
	// ==========================================================
	// Timing
	localparam int CLOCK_PERIOD_PS = 25000;
	localparam int TICK_PERIOD_PS = 1000000;
	localparam int CYCLES_PER_US = TICK_PERIOD_PS / CLOCK_PERIOD_PS;
	localparam int TIME_WORD_PERIOD_US = 1048576;
	// ==========================================================
	// Queue
	localparam int FIFO_DEPTH_WORDS = 131072;
	// ==========================================================
	// Reply sequencer states
	typedef enum logic [2:0] {
		REPLY_IDLE = 3'b001,
		REPLY_HEADER = 3'b010,
		REPLY_DATA = 3'b100
	} reply_state_t;
endpackage

// >>> verilog/stream_buffer2.sv
// Two-entry valid/ready buffer that decouples a producer from a stalling receiver.
`timescale 1ns/100ps
module stream_buffer2 #(
	parameter int WIDTH = 32
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be at least one.");
	end

	typedef struct packed {
		logic [1:0][WIDTH-1:0] entry;
		logic wrSel;
		logic rdSel;
		logic [1:0] fill;
	} buf_state_t;

	buf_state_t s_q, s_d;
	logic push, pop;

	// ==========================================================
	// Handshake
	assign inReady = (s_q.fill != 2'h2);
	assign outValid = (s_q.fill != 2'h0);
	assign outData = s_q.entry[s_q.rdSel];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.entry[s_q.wrSel] = inData;
			s_d.wrSel = ~s_q.wrSel;
		end
		if (pop) begin
			s_d.rdSel = ~s_q.rdSel;
		end
		case ({push, pop})
			2'b10: s_d.fill = s_q.fill + 2'h1;
			2'b01: s_d.fill = s_q.fill - 2'h1;
			default: s_d.fill = s_q.fill;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	a_buffer_order: assert property (@(posedge clock) disable iff (!reset_n)
		(s_q.fill == 2'h1 && push && !pop) |=> outData == $past(s_q.entry[s_q.rdSel]))
		else $error("Buffer reordered its oldest word.");
endmodule
